// *** hw/capture_match_timer.sv ***
module capture_match_timer #(
  parameter int CHANNELS = 4,
  parameter int PINS = 2
) (
  input wire logic pclk, // Peripheral clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [CHANNELS*PINS-1:0] cap_pins, // Capture pins, PINS per channel
  output logic [CHANNELS*PINS-1:0] match_pins, // Match pins, broadcast per channel
  output logic irq // Level interrupt
);
  // Elaboration check: the register map and field packing assume four channels
  if (CHANNELS != 4 || PINS < 1 || PINS > 4)
  begin : g_bad_params
    $error("capture_match_timer: unsupported CHANNELS or PINS");
  end

  // Registers
  logic [1:0] control;
  logic [31:0] count, prescale, pre_cnt, rdata_q;
  logic [11:0] match_ctrl, cap_ctrl;
  logic [31:0] match_val [CHANNELS], cap_val [CHANNELS];
  logic [7:0] out_ctrl, irq_status, irq_mask;
  logic [3:0] mode, pin_and;
  logic [CHANNELS-1:0] match_out, cap_prev, match_prev;
  logic ready_q, err_q;

  logic [1:0] next_control;
  logic [31:0] next_count, next_prescale, next_pre_cnt, next_rdata;
  logic [11:0] next_match_ctrl, next_cap_ctrl;
  logic [31:0] next_match_val [CHANNELS], next_cap_val [CHANNELS];
  logic [7:0] next_out_ctrl, next_irq_status, next_irq_mask;
  logic [3:0] next_mode, next_pin_and;
  logic [CHANNELS-1:0] next_match_out;
  logic next_ready, next_err;

  logic [CHANNELS-1:0] cap_in, match_eq, match_hit;
  cmt_pkg::edge_t cap_edge [CHANNELS];
  cmt_pkg::apb_req_t req;

  // True when a channel's edge is enabled by its two-bit rise/fall select
  function automatic logic edge_hit(input logic [1:0] sel, input cmt_pkg::edge_t e);
    edge_hit = (sel[0] & e.rise) | (sel[1] & e.fall);
  endfunction

  // Combine each channel's pins by OR or AND
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      cap_in[c] = pin_and[c] ? &cap_pins[c*PINS +: PINS] : |cap_pins[c*PINS +: PINS];
      cap_edge[c].rise = cap_in[c] & ~cap_prev[c];
      cap_edge[c].fall = ~cap_in[c] & cap_prev[c];
    end
  end

  // Access phase decode; writes commit at the single ready edge
  always_comb
  begin
    req.wr = psel & penable & pwrite & ~ready_q;
    req.rd = psel & penable & ~pwrite & ~ready_q;
    req.addr = paddr;
    req.wdata = pwdata;
  end

  // Match compare; acts once on arriving at the value, so a resting count toggles once
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      match_eq[c] = control[cmt_pkg::CTRL_ENABLE_BIT] && (count == match_val[c]);
      match_hit[c] = match_eq[c] & ~match_prev[c];
    end
  end

  // Next-state for counter, captures, outputs and registers
  always_comb
  begin
    logic tick, stop, clr;
    logic [1:0] ev_sel;
    logic [7:0] set_ev;
    tick = 1'b0;
    stop = 1'b0;
    clr = 1'b0;
    ev_sel = mode[3:2];
    set_ev = 8'h00;
    next_control = control;
    next_count = count;
    next_prescale = prescale;
    next_pre_cnt = pre_cnt;
    next_match_ctrl = match_ctrl;
    next_cap_ctrl = cap_ctrl;
    next_out_ctrl = out_ctrl;
    next_mode = mode;
    next_irq_mask = irq_mask;
    next_pin_and = pin_and;
    next_match_out = match_out;
    next_irq_status = irq_status;
    next_rdata = 32'h0000_0000;
    next_ready = psel & penable & ~ready_q;
    next_err = 1'b0;
    for (int c = 0; c < CHANNELS; c++)
    begin
      next_match_val[c] = match_val[c];
      next_cap_val[c] = cap_val[c];
    end

    // Count source: pclk or edges of one capture input
    if (control[cmt_pkg::CTRL_ENABLE_BIT])
    begin
      case (mode[1:0])
        cmt_pkg::MODE_TIMER: tick = 1'b1;
        cmt_pkg::MODE_EV_RISE: tick = cap_edge[ev_sel].rise;
        cmt_pkg::MODE_EV_FALL: tick = cap_edge[ev_sel].fall;
        default: tick = cap_edge[ev_sel].rise | cap_edge[ev_sel].fall;
      endcase
    end

    // Match actions: interrupt, reset, stop, drive output
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (match_hit[c])
      begin
        if (match_ctrl[3*c]) set_ev[c] = 1'b1;
        if (match_ctrl[3*c+1]) clr = 1'b1;
        if (match_ctrl[3*c+2]) stop = 1'b1;
        case (out_ctrl[2*c +: 2])
          cmt_pkg::OUT_LOW: next_match_out[c] = 1'b0;
          cmt_pkg::OUT_HIGH: next_match_out[c] = 1'b1;
          cmt_pkg::OUT_TOGGLE: next_match_out[c] = ~match_out[c];
          default: next_match_out[c] = match_out[c];
        endcase
      end
    end

    // Prescaler then counter; reset match or hold restarts both, stop freezes the count
    if (clr || control[cmt_pkg::CTRL_RESET_BIT])
    begin
      next_count = 32'h0000_0000;
      next_pre_cnt = 32'h0000_0000;
    end
    else if (tick && !stop)
    begin
      if (pre_cnt >= prescale)
      begin
        next_pre_cnt = 32'h0000_0000;
        next_count = count + 32'h0000_0001;
      end
      else
        next_pre_cnt = pre_cnt + 32'h0000_0001;
    end
    if (stop) next_control[cmt_pkg::CTRL_ENABLE_BIT] = 1'b0;

    // Captures stay live on every channel, the event input included
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (edge_hit(cap_ctrl[3*c +: 2], cap_edge[c]))
      begin
        next_cap_val[c] = count;
        if (cap_ctrl[3*c+2]) set_ev[4+c] = 1'b1;
      end
    end
    next_irq_status = irq_status | set_ev;

    // Register writes; hardware set wins over write-one-to-clear
    if (req.wr)
    begin
      case (req.addr)
        cmt_pkg::OFS_IRQ_STATUS: next_irq_status = (irq_status & ~req.wdata[7:0]) | set_ev;
        cmt_pkg::OFS_CONTROL: next_control = req.wdata[1:0];
        cmt_pkg::OFS_COUNT: next_count = req.wdata;
        cmt_pkg::OFS_PRESCALE: next_prescale = req.wdata;
        cmt_pkg::OFS_PRESCALE_CNT: next_pre_cnt = req.wdata;
        cmt_pkg::OFS_MATCH_CTRL: next_match_ctrl = req.wdata[11:0];
        cmt_pkg::OFS_CAPTURE_CTRL: next_cap_ctrl = req.wdata[11:0];
        cmt_pkg::OFS_OUT_CTRL: next_out_ctrl = req.wdata[7:0];
        cmt_pkg::OFS_MODE: next_mode = req.wdata[3:0];
        cmt_pkg::OFS_IRQ_MASK: next_irq_mask = req.wdata[7:0];
        cmt_pkg::OFS_PIN_SEL: next_pin_and = req.wdata[3:0];
        default:
        begin
          if (req.addr >= cmt_pkg::OFS_MATCH0 && req.addr < cmt_pkg::OFS_CAPTURE_CTRL
              && req.addr[1:0] == 2'h0)
            next_match_val[req.addr[3:2] - 2'h2] = req.wdata;
          else if (!(req.addr >= cmt_pkg::OFS_CAPTURE0 && req.addr < cmt_pkg::OFS_OUT_CTRL
                     && req.addr[1:0] == 2'h0))
            next_err = 1'b1; // Captures are read only: aligned writes drop silently
        end
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        cmt_pkg::OFS_IRQ_STATUS: next_rdata = {24'h000000, irq_status};
        cmt_pkg::OFS_CONTROL: next_rdata = {30'h00000000, control};
        cmt_pkg::OFS_COUNT: next_rdata = count;
        cmt_pkg::OFS_PRESCALE: next_rdata = prescale;
        cmt_pkg::OFS_PRESCALE_CNT: next_rdata = pre_cnt;
        cmt_pkg::OFS_MATCH_CTRL: next_rdata = {20'h00000, match_ctrl};
        cmt_pkg::OFS_CAPTURE_CTRL: next_rdata = {20'h00000, cap_ctrl};
        cmt_pkg::OFS_OUT_CTRL: next_rdata = {24'h000000, out_ctrl};
        cmt_pkg::OFS_MODE: next_rdata = {28'h0000000, mode};
        cmt_pkg::OFS_IRQ_MASK: next_rdata = {24'h000000, irq_mask};
        cmt_pkg::OFS_PIN_SEL: next_rdata = {28'h0000000, pin_and};
        default:
        begin
          if (req.addr >= cmt_pkg::OFS_MATCH0 && req.addr < cmt_pkg::OFS_CAPTURE_CTRL
              && req.addr[1:0] == 2'h0)
            next_rdata = match_val[req.addr[3:2] - 2'h2];
          else if (req.addr >= cmt_pkg::OFS_CAPTURE0 && req.addr < cmt_pkg::OFS_OUT_CTRL
                   && req.addr[1:0] == 2'h0)
            next_rdata = cap_val[req.addr[3:2] - 2'h3];
          else
            next_err = 1'b1;
        end
      endcase
    end
  end

  // State registers only; constants under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control <= 2'h0;
      count <= cmt_pkg::RESET_WORD;
      prescale <= cmt_pkg::RESET_WORD;
      pre_cnt <= cmt_pkg::RESET_WORD;
      match_ctrl <= 12'h000;
      cap_ctrl <= 12'h000;
      out_ctrl <= 8'h00;
      mode <= 4'h0;
      irq_status <= 8'h00;
      irq_mask <= 8'h00;
      pin_and <= 4'h0;
      match_out <= '0;
      cap_prev <= '0;
      match_prev <= '0;
      match_pins <= '0;
      rdata_q <= cmt_pkg::RESET_WORD;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      irq <= 1'b0;
      for (int c = 0; c < CHANNELS; c++)
      begin
        match_val[c] <= cmt_pkg::RESET_WORD;
        cap_val[c] <= cmt_pkg::RESET_WORD;
      end
    end
    else
    begin
      control <= next_control;
      count <= next_count;
      prescale <= next_prescale;
      pre_cnt <= next_pre_cnt;
      match_ctrl <= next_match_ctrl;
      cap_ctrl <= next_cap_ctrl;
      out_ctrl <= next_out_ctrl;
      mode <= next_mode;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      pin_and <= next_pin_and;
      match_out <= next_match_out;
      cap_prev <= cap_in;
      match_prev <= match_eq;
      rdata_q <= next_rdata;
      ready_q <= next_ready;
      err_q <= next_err;
      irq <= |(next_irq_status & next_irq_mask);
      for (int c = 0; c < CHANNELS; c++)
        match_pins[c*PINS +: PINS] <= {PINS{next_match_out[c]}};
      for (int c = 0; c < CHANNELS; c++)
      begin
        match_val[c] <= next_match_val[c];
        cap_val[c] <= next_cap_val[c];
      end
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
endmodule

// *** include/cmt_pkg.sv ***
package cmt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_PRESCALE = 8'h0C;
  localparam logic [7:0] OFS_PRESCALE_CNT = 8'h10;
  localparam logic [7:0] OFS_MATCH_CTRL = 8'h14;
  localparam logic [7:0] OFS_MATCH0 = 8'h18;
  localparam logic [7:0] OFS_CAPTURE_CTRL = 8'h28;
  localparam logic [7:0] OFS_CAPTURE0 = 8'h2C;
  localparam logic [7:0] OFS_OUT_CTRL = 8'h3C;
  localparam logic [7:0] OFS_MODE = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFS_PIN_SEL = 8'h48;
  // Control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  // Mode fields: [1:0] count source, [3:2] event input select
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_EV_RISE = 2'h1;
  localparam logic [1:0] MODE_EV_FALL = 2'h2;
  localparam logic [1:0] MODE_EV_BOTH = 2'h3;
  // Match output actions
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;
  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // APB request carrier shared by all channels
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  // Edge qualification per capture channel
  typedef struct packed {
    logic rise;
    logic fall;
  } edge_t;
endpackage

// *** verification/cmt_assertions.sv ***
module cmt_assertions #(
  parameter int CHANNELS = 4,
  parameter int PINS = 2
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [CHANNELS*PINS-1:0] cap_pins, // Capture pins
  input wire logic [CHANNELS*PINS-1:0] match_pins, // Match pins
  input wire logic irq // Interrupt
);
  logic bc_ok;
  logic unmapped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Every pin of a channel carries the same match output
  always_comb
  begin
    bc_ok = 1'b1;
    for (int c = 0; c < CHANNELS; c++)
      if (match_pins[c*PINS +: PINS] != {PINS{match_pins[c*PINS]}})
        bc_ok = 1'b0;
  end
  // Words above the last register and unaligned addresses anywhere must be refused
  assign unmapped = paddr > 8'h48 || paddr[1:0] != 2'h0;
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_map: assert property (pready |-> pslverr == unmapped)
    else $error("error flag disagrees with address map");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_pins_broadcast: assert property (bc_ok)
    else $error("match pins of a channel differ");
  a_reset_quiet: assert property (!$past(presetn) |-> !irq && !pready && match_pins == '0)
    else $error("outputs active after reset");
  a_irq_clear: assert property ($fell(irq) |-> $past(psel && penable && pwrite && !pready))
    else $error("interrupt dropped without a write");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_pins: cover property ($changed(match_pins));
endmodule

bind capture_match_timer cmt_assertions #(.CHANNELS(CHANNELS), .PINS(PINS)) u_cmt_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cap_pins(cap_pins), .match_pins(match_pins), .irq(irq));

// *** verification/ext_events.sv ***
module ext_events (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [7:0] fire, // One-cycle request per pin
  output logic [7:0] cap_pins // External event lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last;
  // Stretch each request to two cycles so no edge is too short to be seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last <= 8'h00;
      cap_pins <= 8'h00;
    end
    else
    begin
      last <= fire;
      cap_pins <= fire | last;
    end
  end
endmodule

// *** verification/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr, fire, cap_pins, match_pins;
  logic [31:0] pwdata, prdata, q;
  int err_count, n_checks, cyc, k, n, seed;
  logic [7:0] offs [5] = '{cmt_pkg::OFS_CONTROL, cmt_pkg::OFS_COUNT, cmt_pkg::OFS_PRESCALE,
    cmt_pkg::OFS_MODE, cmt_pkg::OFS_IRQ_MASK};
  capture_match_timer u_capture_match_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_pins(cap_pins), .match_pins(match_pins), .irq(irq));
  ext_events u_ext_events (.pclk(pclk), .presetn(presetn), .fire(fire), .cap_pins(cap_pins));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole sequence needs a few hundred cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request stands until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, q);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge pclk);
    fire <= m;
    @(posedge pclk);
    fire <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask
  initial
  begin
    seed = 32'hC724;
    {presetn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(offs[i], cmt_pkg::RESET_WORD, "reset value");
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    $display("test reset done");
    k = 4 + ($unsigned($random(seed)) % 30);
    apb(1'b1, cmt_pkg::OFS_PRESCALE, 32'h0000_0001);
    apb(1'b1, cmt_pkg::OFS_MATCH0, 32'(k));
    apb(1'b1, cmt_pkg::OFS_MATCH_CTRL, 32'h0000_0005);
    apb(1'b1, cmt_pkg::OFS_OUT_CTRL, {30'h0, cmt_pkg::OUT_HIGH});
    apb(1'b1, cmt_pkg::OFS_CAPTURE_CTRL, 32'h0000_0028);
    apb(1'b1, cmt_pkg::OFS_IRQ_MASK, 32'h0000_0021);
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0001);
    n = 0;
    while (irq !== 1'b1 && n < 500)
    begin
      @(negedge pclk);
      n++;
    end
    chk("irq on match", 32'h0000_0001, {31'h0, irq});
    chk("match pins", 32'h0000_0003, {30'h0, match_pins[1:0]});
    rd(cmt_pkg::OFS_COUNT, 32'(k), "stopped count");
    pulse(8'h01 << (2 + ($unsigned($random(seed)) % 2)));
    rd(cmt_pkg::OFS_CAPTURE0 + 8'h04, 32'(k), "capture one");
    apb(1'b1, cmt_pkg::OFS_CAPTURE0 + 8'h04, 32'hFFFF_FFFF);
    rd(cmt_pkg::OFS_CAPTURE0 + 8'h04, 32'(k), "capture read only");
    rd(cmt_pkg::OFS_IRQ_STATUS, 32'h0000_0021, "status");
    apb(1'b1, cmt_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0000);
    apb(1'b1, cmt_pkg::OFS_IRQ_STATUS, 32'h0000_0021);
    rd(cmt_pkg::OFS_IRQ_STATUS, 32'h0000_0000, "status cleared");
    $display("test match and capture done");
    n = 3 + ($unsigned($random(seed)) % 8);
    apb(1'b1, cmt_pkg::OFS_MATCH_CTRL, 32'h0000_0000);
    apb(1'b1, cmt_pkg::OFS_PRESCALE, 32'h0000_0000);
    apb(1'b1, cmt_pkg::OFS_MODE, {28'h0, 2'h2, cmt_pkg::MODE_EV_RISE});
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0002);
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0001);
    repeat (n) pulse(8'h01 << (4 + ($unsigned($random(seed)) % 2)));
    rd(cmt_pkg::OFS_COUNT, 32'(n), "event count");
    pulse(8'h08);
    rd(cmt_pkg::OFS_CAPTURE0 + 8'h04, 32'(n), "capture in event mode");
    $display("test event count done");
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0002);
    apb(1'b1, cmt_pkg::OFS_MODE, {28'h0, 2'h0, cmt_pkg::MODE_EV_BOTH});
    apb(1'b1, cmt_pkg::OFS_PIN_SEL, 32'h0000_0001);
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0001);
    pulse(8'h01);
    pulse(8'h03);
    rd(cmt_pkg::OFS_COUNT, 32'h0000_0002, "and pins both edges");
    apb(1'b1, cmt_pkg::OFS_MODE, {28'h0, 2'h0, cmt_pkg::MODE_EV_FALL});
    pulse(8'h03);
    pulse(8'h02);
    rd(cmt_pkg::OFS_COUNT, 32'h0000_0003, "and pins falling edge");
    $display("test pin combine done");
    k = 3 + ($unsigned($random(seed)) % 5);
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0002);
    apb(1'b1, cmt_pkg::OFS_MODE, {28'h0, 2'h0, cmt_pkg::MODE_TIMER});
    apb(1'b1, cmt_pkg::OFS_MATCH0 + 8'h0C, 32'(k));
    apb(1'b1, cmt_pkg::OFS_MATCH_CTRL, 32'h0000_0400);
    apb(1'b1, cmt_pkg::OFS_OUT_CTRL, {24'h0, cmt_pkg::OUT_TOGGLE, 6'h00});
    apb(1'b1, cmt_pkg::OFS_CONTROL, 32'h0000_0001);
    n = 0;
    while (match_pins[6] !== 1'b1 && n < 100)
    begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (match_pins[6] === 1'b1 && n < 100)
    begin
      @(negedge pclk);
      n++;
    end
    chk("toggle period", 32'(k + 1), 32'(n));
    chk("held output", 32'h0000_0003, {30'h0, match_pins[1:0]});
    $display("test reset match and toggle done");
    conclude();
  end
endmodule
